// ==== sim/cpu_bus_model.sv ====
/* Classic Wishbone master standing in for CPU software.
   Assumes callers enter its task just after a rising clock edge. */
`timescale 1ns/1ps
module cpu_bus_model (
    input wire logic i_clk_sys,
    input wire logic i_ack,
    input wire logic [31:0] i_dat,
    output logic o_cyc,
    output logic o_stb,
    output logic o_we,
    output logic [7:0] o_adr,
    output logic [3:0] o_sel,
    output logic [31:0] o_dat
);
    initial begin
        {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} = '0;
    end
    // Ack and read data are taken at the rising edge, where the request still stands
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        o_cyc <= 1'b1;
        o_stb <= 1'b1;
        o_we <= we;
        o_adr <= a;
        o_sel <= 4'hF;
        o_dat <= d;
        do @(posedge i_clk_sys); while (i_ack !== 1'b1);
        q = i_dat;
        o_cyc <= 1'b0;
        o_stb <= 1'b0;
        o_we <= 1'b0;
        @(posedge i_clk_sys);
    endtask : xfer
endmodule : cpu_bus_model

// ==== sim/tb.sv ====
/* Self-checking bench of the timer compare block.
   Assumes the bus model above and a 20 MHz system clock. */
`timescale 1ns/1ps
module tb;
    import timer16_pkg::*;
    typedef struct packed {
        logic [7:0] adr;
        logic [31:0] wd;
        logic [31:0] rd;
    } row_t;
    logic clk, rst, cyc, stb, we, ack;
    logic [7:0] adr;
    logic [3:0] sel, irq_ack, flags, f_s;
    logic [31:0] wdat, rdat, q;
    logic [1:0] pin, oe, p_s;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    int n;
    row_t rows [7] = '{'{ADDR_CMP_A, 32'hFFFF1234, 32'h1234}, '{ADDR_CMP_B, 32'hABCD, 32'hABCD},
        '{ADDR_CAPT, 32'h0F0F, 32'h0F0F}, '{ADDR_COUNT, 32'h5555, 32'h5555},
        '{8'h20, 32'hFFFF, 32'h0}, '{ADDR_FORCE, 32'h3, 32'h0}, '{ADDR_CTRL, 32'h34, 32'h34}};
    logic [2:0] cs_tab [5] = '{CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024};
    int dv_tab [5] = '{1, 8, 64, 256, 1024};
    logic [1:0] act_tab [4] = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_NONE};
    logic st_tab [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    cpu_bus_model u_cpu_bus_model (.i_clk_sys(clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc),
        .o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat));
    timer16_compare_output u_timer16_compare_output (.i_clk_sys(clk), .i_rst(rst),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
        .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_irq_ack(irq_ack),
        .o_flags(flags), .o_pin_out(pin), .o_pin_oe(oe));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] cw(logic [2:0] cs, logic [1:0] act, logic [3:0] m);
        return {21'h0, ctrl_t'{cs, ACT_NONE, act, m}};
    endfunction : cw
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        u_cpu_bus_model.xfer(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        u_cpu_bus_model.xfer(1'b0, a, 32'h0, r);
    endtask : rd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_n(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t cycles %0d expected %0d", $time, got, exp);
        end
    endtask : chk_n
    task automatic snap();
        @(negedge clk);
        f_s = flags;
        p_s = pin;
        @(posedge clk);
    endtask : snap
    // Cycles between two pin A edges, once the prescaler phase has settled
    task automatic half(output int c);
        logic p;
        @(negedge clk);
        p = pin[0];
        while (pin[0] === p) @(negedge clk);
        p = pin[0];
        c = 0;
        while (pin[0] === p) begin
            @(negedge clk);
            c++;
        end
        @(posedge clk);
    endtask : half
    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        rst = 1'b1;
        irq_ack = 4'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(ADDR_PORT, q);
        snap();
        chk({q[15:0], 10'h0, f_s, p_s}, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].adr, rows[i].wd);
            rd(rows[i].adr, q);
            chk(q, rows[i].rd);
        end
        $display("test registers done");
        wr(ADDR_CTRL, cw(CS_STOP, ACT_CLEAR, MODE_NORMAL));
        wr(ADDR_FORCE, 32'h1);
        wr(ADDR_PORT, 32'h4);
        foreach (act_tab[i]) begin
            wr(ADDR_CTRL, cw(CS_STOP, act_tab[i], MODE_NORMAL));
            wr(ADDR_FORCE, 32'h1);
            rd(ADDR_PORT, q);
            snap();
            chk(32'(q[PORT_OC_LSB]), 32'(st_tab[i]));
            chk(32'(p_s[0]), 32'(act_tab[i] != ACT_NONE && st_tab[i]));
        end
        wr(ADDR_CTRL, cw(CS_STOP, ACT_NONE, MODE_CTC_CAPT));
        wr(ADDR_CTRL, 32'hF);
        rd(ADDR_PORT, q);
        chk(32'(q[PORT_OC_LSB]), 32'h1);
        rd(ADDR_COUNT, q);
        chk({q[15:0], 12'h0, f_s}, 32'h55550000);
        $display("test force done");
        wr(ADDR_CMP_A, 32'h10);
        wr(ADDR_CMP_B, 32'h11);
        wr(ADDR_COUNT, 32'h10);
        wr(ADDR_CTRL, cw(CS_DIV1, ACT_NONE, MODE_NORMAL));
        repeat (20) @(posedge clk);
        wr(ADDR_CTRL, 32'h0);
        snap();
        chk(32'(f_s[2:1]), 32'h2);
        wr(ADDR_FLAGS, 32'h1 << FLAG_CMP_B);
        snap();
        chk(32'(f_s), 32'h0);
        wr(ADDR_COUNT, 32'hFFFD);
        wr(ADDR_CTRL, cw(CS_DIV1, ACT_NONE, MODE_NORMAL));
        wr(ADDR_CTRL, 32'h0);
        rd(ADDR_COUNT, q);
        snap();
        chk({q[15:8], 20'h0, f_s}, 32'h1);
        irq_ack <= 4'h1;
        @(posedge clk);
        irq_ack <= 4'h0;
        snap();
        chk(32'(f_s), 32'h0);
        $display("test flags done");
        wr(ADDR_CMP_A, 32'h3);
        foreach (cs_tab[i]) begin
            wr(ADDR_CTRL, cw(cs_tab[i], ACT_TOGGLE, MODE_CTC_CMP));
            half(n);
            chk_n(n, dv_tab[i] * 4);
        end
        wr(ADDR_CAPT, 32'h5);
        wr(ADDR_FLAGS, 32'hF);
        wr(ADDR_CTRL, cw(CS_DIV1, ACT_TOGGLE, MODE_CTC_CAPT));
        half(n);
        chk_n(n, 6);
        snap();
        chk(32'(f_s[FLAG_CAPT]), 32'h1);
        wr(ADDR_CMP_A, 32'h7);
        wr(ADDR_FLAGS, 32'hF);
        repeat (8) @(posedge clk);
        snap();
        chk(32'(f_s), 32'h8);
        $display("test clear on match done");
        report_and_stop();
    end
endmodule : tb

// ==== sim/timer16_compare_output_asserts.sv ====
/* Concurrent checks on the ports of the timer compare block.
   Assumes a single system clock domain and synchronous reset. */
`timescale 1ns/1ps
module timer16_compare_output_asserts
    import timer16_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic [3:0] i_irq_ack,
    input wire logic [3:0] o_flags,
    input wire logic [1:0] o_pin_out,
    input wire logic [1:0] o_pin_oe
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    wire wr_ack = o_wb_ack && i_wb_we && i_wb_sel[0];
    wire [3:0] clr_now = i_irq_ack | ({4{wr_ack && i_wb_adr == ADDR_FLAGS}} & i_wb_dat[3:0]);
    logic [1:0] dir_q;
    logic [1:0] quiet;
    // Pin enable may lag the register write by one clock
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            dir_q <= 2'h0;
            quiet <= 2'h3;
        end else if (wr_ack && i_wb_adr == ADDR_PORT) begin
            dir_q <= i_wb_dat[3:2];
            quiet <= 2'h0;
        end else if (quiet != 2'h3) begin
            quiet <= quiet + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
    ack_latency_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("ack not one cycle after request");
    ack_cause_a: assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb))
        else $error("ack without request");
    unmapped_zero_a: assert property (o_wb_ack && !i_wb_we && (i_wb_adr > ADDR_PORT
        || i_wb_adr[1:0] != 2'h0 || i_wb_adr == ADDR_FORCE) |-> o_wb_dat == 32'h0)
        else $error("unmapped read not zero");
    pin_gate_a: assert property ((o_pin_out & ~o_pin_oe) == 2'h0)
        else $error("pin driven value while input");
    dir_follow_a: assert property (quiet >= 2'h2 |-> o_pin_oe == dir_q)
        else $error("pin enable differs from direction");
    reset_clear_a: assert property ($past(i_rst) |-> o_flags == 4'h0 && o_pin_out == 2'h0)
        else $error("outputs not cleared by reset");
    flag_hold_a: assert property ((($past(o_flags) & ~o_flags) & ~$past(clr_now)) == 4'h0)
        else $error("flag cleared without cause");
    cover property (wr_ack && i_wb_adr == ADDR_FORCE);
    cover property ($rose(o_flags[FLAG_OVF]));
    cover property ($rose(o_pin_out[0]));
endmodule : timer16_compare_output_asserts

bind timer16_compare_output timer16_compare_output_asserts u_timer16_compare_output_asserts (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_irq_ack(i_irq_ack), .o_flags(o_flags),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));

// ==== verilog/timer16_compare_output.sv ====
/*
 * 16-bit timer/counter with two output compare channels, normal and
 * clear-on-match modes, overflow/compare/capture flags and pin override.
 * Assumes a classic Wishbone master on the system clock, an interrupt
 * controller outside that pulses i_irq_ack when it takes a flag's vector,
 * and a pad that drives o_pin_out while o_pin_oe is high.
 */
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps

module timer16_compare_output
    import timer16_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic [3:0] i_irq_ack,
    output logic [3:0] o_flags,
    output logic [1:0] o_pin_out,
    output logic [1:0] o_pin_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    ctrl_t ctrl_reg;
    logic [15:0] count_reg;
    logic [1:0][15:0] cmp_reg;
    logic [15:0] capt_reg;
    logic [3:0] flag_reg;
    logic [1:0] port_val_reg;
    logic [1:0] dir_reg;
    logic [1:0] oc_reg;
    logic [1:0] pin_out_reg;
    logic [1:0] pin_oe_reg;
    logic block_reg;
    logic [9:0] presc_reg;
    logic ack_reg;
    logic [31:0] dat_reg;

    logic access;
    logic wr;
    logic [15:0] wmask;
    logic wr_count;
    logic [1:0] force_strobe;
    logic non_pwm;
    logic clear_on_match_mode;
    logic tick;
    logic [15:0] top_val;
    logic top_hit;
    logic [1:0] match;
    logic capt_hit;
    logic ovf_hit;
    logic [3:0] flag_set;
    logic [3:0] flag_clr;
    logic [31:0] rdata;

    function automatic logic [15:0] merge(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [15:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: ack one cycle after the request, writes land on the
    // edge where the master samples ack, so a request held past ack writes again two cycles later
    assign access = i_wb_cyc & i_wb_stb;
    assign wr = access & ack_reg & i_wb_we;
    assign wmask = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    assign wr_count = wr && (i_wb_adr == ADDR_COUNT);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access & ~ack_reg;
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (i_wb_adr)
            ADDR_CTRL: rdata[10:0] = ctrl_reg;
            ADDR_COUNT: rdata[15:0] = count_reg;
            ADDR_CMP_A: rdata[15:0] = cmp_reg[0];
            ADDR_CMP_B: rdata[15:0] = cmp_reg[1];
            ADDR_CAPT: rdata[15:0] = capt_reg;
            ADDR_FLAGS: rdata[3:0] = flag_reg;
            ADDR_PORT: begin
                rdata[PORT_VAL_LSB +: 2] = port_val_reg;
                rdata[PORT_DIR_LSB +: 2] = dir_reg;
                rdata[PORT_OC_LSB +: 2] = oc_reg;
            end
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            dat_reg <= 32'h0000_0000;
        end else if (access & ~ack_reg) begin
            dat_reg <= rdata;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ctrl_reg <= CTRL_RST;
            cmp_reg <= '0;
            capt_reg <= COUNT_BOTTOM;
            port_val_reg <= 2'h0;
            dir_reg <= 2'h0;
        end else if (wr) begin
            unique case (i_wb_adr)
                ADDR_CTRL: ctrl_reg <= 11'(merge(16'(ctrl_reg), i_wb_dat[15:0], wmask));
                ADDR_CMP_A: cmp_reg[0] <= merge(cmp_reg[0], i_wb_dat[15:0], wmask);
                ADDR_CMP_B: cmp_reg[1] <= merge(cmp_reg[1], i_wb_dat[15:0], wmask);
                ADDR_CAPT: capt_reg <= merge(capt_reg, i_wb_dat[15:0], wmask);
                ADDR_PORT: begin
                    if (i_wb_sel[0]) begin
                        port_val_reg <= i_wb_dat[PORT_VAL_LSB +: 2];
                        dir_reg <= i_wb_dat[PORT_DIR_LSB +: 2];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    assign force_strobe = (wr && (i_wb_adr == ADDR_FORCE) && i_wb_sel[0]) ?
                          i_wb_dat[1:0] : 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler: free running, so a newly selected divider may give a short
    // first period; the trade keeps the divider a single counter
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            presc_reg <= 10'h000;
        end else begin
            presc_reg <= presc_reg + 10'h001;
        end
    end

    always_comb begin
        unique case (ctrl_reg.clk_sel)
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = (presc_reg & DIV8_M1) == DIV8_M1;
            CS_DIV64: tick = (presc_reg & DIV64_M1) == DIV64_M1;
            CS_DIV256: tick = (presc_reg & DIV256_M1) == DIV256_M1;
            CS_DIV1024: tick = presc_reg == DIV1024_M1;
            default: tick = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Match detection; mode alone shapes counting
    assign non_pwm = (ctrl_reg.waveform_mode_select == MODE_NORMAL) ||
                     (ctrl_reg.waveform_mode_select == MODE_CTC_CMP) ||
                     (ctrl_reg.waveform_mode_select == MODE_CTC_CAPT);
    assign clear_on_match_mode = (ctrl_reg.waveform_mode_select == MODE_CTC_CMP) ||
                 (ctrl_reg.waveform_mode_select == MODE_CTC_CAPT);
    assign top_val = (ctrl_reg.waveform_mode_select == MODE_CTC_CAPT) ?
                     capt_reg : cmp_reg[0];
    // Unbuffered top: a top below the count is only met after the wrap
    assign top_hit = tick & clear_on_match_mode & ~block_reg & (count_reg == top_val);
    assign capt_hit = tick & ~block_reg & (count_reg == capt_reg) &
                      (ctrl_reg.waveform_mode_select == MODE_CTC_CAPT);
    assign ovf_hit = tick & non_pwm & (count_reg == COUNT_MAX);

    // Counter write blocks the match for one timer clock even while stopped
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            block_reg <= 1'b0;
        end else if (wr_count) begin
            block_reg <= 1'b1;
        end else if (tick) begin
            block_reg <= 1'b0;
        end
    end

    // Software write wins over the timer step
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            count_reg <= COUNT_BOTTOM;
        end else if (wr_count) begin
            count_reg <= merge(count_reg, i_wb_dat[15:0], wmask);
        end else if (tick) begin
            if (top_hit) begin
                count_reg <= COUNT_BOTTOM;
            end else begin
                count_reg <= count_reg + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output compare channels
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic [1:0] act;
            logic apply;

            assign act = (ch == 0) ? ctrl_reg.output_action_select_a :
                                     ctrl_reg.output_action_select_b;
            assign match[ch] = tick & ~block_reg & (count_reg == cmp_reg[ch]);
            assign apply = non_pwm & (match[ch] | force_strobe[ch]);

            // Mode writes never touch this register
            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    oc_reg[ch] <= 1'b0;
                end else if (apply) begin
                    unique case (act)
                        ACT_TOGGLE: oc_reg[ch] <= ~oc_reg[ch];
                        ACT_CLEAR: oc_reg[ch] <= 1'b0;
                        ACT_SET: oc_reg[ch] <= 1'b1;
                        ACT_NONE: oc_reg[ch] <= oc_reg[ch];
                    endcase
                end
            end

            // Pin low while not driven, so nothing leaks before the setup
            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    pin_out_reg[ch] <= 1'b0;
                    pin_oe_reg[ch] <= 1'b0;
                end else begin
                    pin_out_reg[ch] <= dir_reg[ch] &
                        ((act != ACT_NONE) ? oc_reg[ch] : port_val_reg[ch]);
                    pin_oe_reg[ch] <= dir_reg[ch];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Flags: a set in the same cycle as a clear wins
    always_comb begin
        flag_set = 4'h0;
        flag_set[FLAG_OVF] = ovf_hit;
        flag_set[FLAG_CMP_A] = match[0];
        flag_set[FLAG_CMP_B] = match[1];
        flag_set[FLAG_CAPT] = capt_hit;
    end

    assign flag_clr = i_irq_ack |
        ((wr && (i_wb_adr == ADDR_FLAGS) && i_wb_sel[0]) ? i_wb_dat[3:0] : 4'h0);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            flag_reg <= 4'h0;
        end else begin
            flag_reg <= (flag_reg & ~flag_clr) | flag_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign o_wb_ack = ack_reg;
    assign o_wb_dat = dat_reg;
    assign o_flags = flag_reg;
    assign o_pin_out = pin_out_reg;
    assign o_pin_oe = pin_oe_reg;

endmodule : timer16_compare_output

// ==== verilog/timer16_pkg.sv ====
/*
 * Constants, field layout and carrier types of the 16-bit timer compare
 * and waveform output block (normal and clear-on-match modes).
 * Assumes a 32-bit classic Wishbone slave port and a 20 MHz system clock.
 */
// Function
// - A counter write blocks every compare match in the next timer clock cycle.
// - Writing the counter equal to a variable top skips that top match.
// - Changing waveform mode leaves each output state register unchanged.
// - Output action bits are unbuffered; new value governs the next match.
// - Reset clears each output state register to zero.
// - Nonzero output action puts output state on the pin, not port value.
// - The pin drives only while its direction bit selects output.
// - Output action zero leaves the output state unchanged on a match.
// - In non-PWM modes the force strobe applies the action like a match.
// - Counting depends only on the waveform mode, never on output action.
// - Non-PWM actions are toggle, clear or set on compare match.
// - Mode 0 counts up without clearing and wraps 0xFFFF to 0x0000.
// - Normal mode sets overflow flag as the counter becomes zero; never clears.
// - Taking the overflow interrupt clears the overflow flag.
// - In normal mode a counter write is accepted at any time.
// - Mode 4 clears at compare A match; mode 12 at capture value match.
// - Clear-on-match top sets compare A flag or capture flag.
// - Top is unbuffered; a top below the count runs through 0xFFFF first.
// - Mode clear-on-match with action 1 toggles output A on each match.
// - Timer clock divides the I/O clock by 1, 8, 64, 256 or 1024.
// - Clear-on-match sets overflow flag when the counter steps max to zero.
// - A compare match sets its flag one timer clock after equality.
// - A forced match changes only output state, no flag, no counter change.
// - Writing one to a flag clears it; taking its interrupt clears it too.
package timer16_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_CMP_A = 8'h08;
    localparam logic [7:0] ADDR_CMP_B = 8'h0C;
    localparam logic [7:0] ADDR_CAPT = 8'h10;
    localparam logic [7:0] ADDR_FLAGS = 8'h14;
    localparam logic [7:0] ADDR_FORCE = 8'h18;
    localparam logic [7:0] ADDR_PORT = 8'h1C;

    localparam int FLAG_OVF = 0;
    localparam int FLAG_CMP_A = 1;
    localparam int FLAG_CMP_B = 2;
    localparam int FLAG_CAPT = 3;
    localparam int PORT_VAL_LSB = 0;
    localparam int PORT_DIR_LSB = 2;
    localparam int PORT_OC_LSB = 4;

    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_CTC_CMP = 4'h4;
    localparam logic [3:0] MODE_CTC_CAPT = 4'hC;

    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [9:0] DIV8_M1 = 10'h007;
    localparam logic [9:0] DIV64_M1 = 10'h03F;
    localparam logic [9:0] DIV256_M1 = 10'h0FF;
    localparam logic [9:0] DIV1024_M1 = 10'h3FF;

    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam logic [10:0] CTRL_RST = 11'h000;

    typedef struct packed {
        logic [2:0] clk_sel;
        logic [1:0] output_action_select_b;
        logic [1:0] output_action_select_a;
        logic [3:0] waveform_mode_select;
    } ctrl_t;

endpackage : timer16_pkg
